/* File: vrl_consts.svh */
`ifndef VRL_CONSTS_SVH
`define VRL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define VRL_ADDR_MODE      12'h430
`define VRL_ADDR_TUNE      12'h434
`define VRL_ADDR_STAT      12'h438
`define VRL_ADDR_CBA       12'h559
`define VRL_ADDR_CBB       12'h55a

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define VRL_MODE_EN        0
`define VRL_MODE_CPLX      1
`define VRL_MODE_BW43      2
`define VRL_TUNE_MSB       3
`define VRL_CB0_LSB        0
`define VRL_CB1_LSB        4
`define VRL_CB2_LSB        0
`define VRL_STAT_FLAG      4
`define VRL_REG_RST        8'h00
`define VRL_TUNE_RL_MIN    4'h2
`define VRL_TUNE_RL_MAX    4'h6

// ----------------------------------------------------------------------
// Data path
// ----------------------------------------------------------------------
`define VRL_NCH            2
`define VRL_SMP_W          14
`define VRL_OUT_W          16
`define VRL_FIFO_DEPTH     16
`define VRL_MIX_SH         7
`define VRL_DECAY_SH       8
`define VRL_LVL_W          17
`define VRL_DROP_MAX       3'h5

// ----------------------------------------------------------------------
// Mask level thresholds: -30, -24, -18, -12 and -6 dBFS of 8191
// ----------------------------------------------------------------------
`define VRL_THR_M30        17'h00103
`define VRL_THR_M24        17'h00205
`define VRL_THR_M18        17'h00407
`define VRL_THR_M12        17'h00809
`define VRL_THR_M06        17'h01009

`endif

/* File: vrl_pkg.sv */
`default_nettype none

package vrl_pkg;

  typedef enum logic [1:0] {
    VRL_CB_NONE,
    VRL_CB_FLAG,
    VRL_CB_PEN_HI,
    VRL_CB_PEN_LO
  } vrl_cb_sel_e;

  typedef logic [2:0] vrl_drop_t;

endpackage

`default_nettype wire

/* File: vrl_stream_if.sv */
`default_nettype none

interface vrl_stream_if #(
  parameter int W = 32
) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

/* File: vrl_fifo.sv */
`default_nettype none

module vrl_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic   sys_clk_in,
  input  wire logic   rstn_in,
  vrl_stream_if.snk   push_s,
  vrl_stream_if.src   pop_s
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  logic          do_push;
  logic          do_pop;

  assign push_s.ready = (count_q != (AW+1)'(DEPTH));
  assign pop_s.valid  = (count_q != '0);
  assign pop_s.data   = mem_q[rd_ptr_q];
  assign do_push      = push_s.valid && push_s.ready;
  assign do_pop       = pop_s.valid && pop_s.ready;

  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= push_s.data;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: vrl_zone_meter.sv */
`include "vrl_consts.svh"
`default_nettype none

module vrl_zone_meter (
  input  wire logic                          sys_clk_in,
  input  wire logic                          rstn_in,
  input  wire logic                          sample_en_in,
  input  wire logic                          enable_in,
  input  wire logic                          complex_in,
  input  wire logic                          bw43_in,
  input  wire logic [`VRL_TUNE_MSB:0]        tune_in,
  input  wire logic signed [`VRL_SMP_W-1:0]  i_in,
  input  wire logic signed [`VRL_SMP_W-1:0]  q_in,
  output logic [`VRL_LVL_W-1:0]              peak_out
);

  // ----------------------------------------------------------------------
  // Mixer table
  // ----------------------------------------------------------------------
  function automatic logic signed [7:0] cos_lut(input logic [3:0] p);
    case (p)
      4'h0: cos_lut = 8'sh7f;
      4'h1: cos_lut = 8'sh75;
      4'h2: cos_lut = 8'sh5a;
      4'h3: cos_lut = 8'sh31;
      4'h4: cos_lut = 8'sh00;
      4'h5: cos_lut = 8'shcf;
      4'h6: cos_lut = 8'sha6;
      4'h7: cos_lut = 8'sh8b;
      4'h8: cos_lut = 8'sh81;
      4'h9: cos_lut = 8'sh8b;
      4'ha: cos_lut = 8'sha6;
      4'hb: cos_lut = 8'shcf;
      4'hc: cos_lut = 8'sh00;
      4'hd: cos_lut = 8'sh31;
      4'he: cos_lut = 8'sh5a;
      default: cos_lut = 8'sh75;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Mask zone estimate
  // ----------------------------------------------------------------------
  // The passband is shifted to DC and a first difference rejects it; this
  // is a coarse estimate traded for area against a true band filter.
  logic [3:0]                    phase_q;
  logic signed [`VRL_SMP_W-1:0]  q_eff;
  logic signed [22:0]            mix_full;
  logic signed [15:0]            mix;
  logic signed [15:0]            mix_prev_q;
  logic signed [16:0]            diff;
  logic [16:0]                   mag;
  logic [16:0]                   mag_bw;

  assign q_eff    = complex_in ? q_in : '0;
  assign mix_full = 23'(i_in * cos_lut(phase_q)) + 23'(q_eff * cos_lut(phase_q - 4'h4));
  assign mix      = 16'(mix_full >>> `VRL_MIX_SH);
  assign diff     = 17'(mix) - 17'(mix_prev_q);
  assign mag      = diff[16] ? 17'(-diff) : 17'(diff);
  assign mag_bw   = (complex_in && bw43_in) ? (mag >> 1) : mag;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_q    <= '0;
      mix_prev_q <= '0;
    end else if (sample_en_in) begin
      phase_q    <= phase_q + tune_in;
      mix_prev_q <= mix;
    end
  end

  // Peak hold with slow decay so resolution recovers gradually.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      peak_out <= '0;
    end else if (!enable_in) begin
      peak_out <= '0;
    end else if (sample_en_in) begin
      if (mag_bw > peak_out) begin
        peak_out <= mag_bw;
      end else begin
        peak_out <= peak_out - (peak_out >> `VRL_DECAY_SH);
      end
    end
  end

endmodule

`default_nettype wire

/* File: vrl_limiter.sv */
// Operation
// - Keep 14 bits in passband, never fewer than 9 bits anywhere.
// - No attenuation; only the output resolution is lowered.
// - Each channel has its own enable and configuration registers.
// - Complex mode offers 25% or 43% bandwidth; real mode only 25%.
// - Mode and bandwidth come from the mode register and shape the mask.
// - Peak level in the mask zones decides how many bits to remove.
// - Penalty code and flag may be placed in the stream as control bits.
// - Flag fits any control bit; 1 when reduced, 0 at full resolution.
// - Penalty 00=14, 01=13, 10=12 or 11, 11=10 or 9 bits.
// - Mask level at or below -30 dBFS keeps full resolution.
// - One bit dropped per 6 dB above -30 dBFS, down to 9 bits.
// - Center tuning code sits in bits 3 to 0 of the tuning register.
// - Complex mode centers step by fs/16 over the whole band.
// - Real mode accepts tuning codes 2 to 6 only; other codes are stored but clamped to 2 or 6.
// - Real mode code n centers at n/16 with quarter-rate passband.
`include "vrl_consts.svh"
`default_nettype none

module vrl_limiter (
  input  wire logic                                  sys_clk_in,
  input  wire logic                                  rstn_in,
  input  wire logic [11:0]                           reg_addr_in,
  input  wire logic [`VRL_NCH-1:0]                   reg_chan_in,
  input  wire logic                                  reg_wr_in,
  input  wire logic                                  reg_rd_in,
  input  wire logic [7:0]                            reg_wdata_in,
  output logic [7:0]                                 reg_rdata_out,
  input  wire logic                                  smp_valid_in,
  output logic                                       smp_ready_out,
  input  wire logic [`VRL_NCH*`VRL_SMP_W-1:0]        smp_data_in,
  output logic                                       out_valid_out,
  input  wire logic                                  out_ready_in,
  output logic [`VRL_NCH*`VRL_OUT_W-1:0]             out_data_out,
  output logic [`VRL_NCH-1:0]                        reduced_out
);

  // ----------------------------------------------------------------------
  // Control bit selection
  // ----------------------------------------------------------------------
  function automatic logic cb_pick(input logic [1:0] sel,
                                   input logic       flag,
                                   input logic [1:0] pen);
    case (vrl_pkg::vrl_cb_sel_e'(sel))
      vrl_pkg::VRL_CB_NONE:   cb_pick = 1'b0;
      vrl_pkg::VRL_CB_FLAG:   cb_pick = flag;
      vrl_pkg::VRL_CB_PEN_HI: cb_pick = pen[1];
      vrl_pkg::VRL_CB_PEN_LO: cb_pick = pen[0];
      default:                cb_pick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Stream handshake
  // ----------------------------------------------------------------------
  vrl_stream_if #(.W(`VRL_NCH*`VRL_OUT_W)) push_s ();
  vrl_stream_if #(.W(`VRL_NCH*`VRL_OUT_W)) pop_s ();

  logic sample_en;

  // A full FIFO stalls the meters as well, so no sample is measured twice.
  assign sample_en     = smp_valid_in && push_s.ready;
  assign smp_ready_out = push_s.ready;
  assign push_s.valid  = smp_valid_in;
  assign out_valid_out = pop_s.valid;
  assign out_data_out  = pop_s.data;
  assign pop_s.ready   = out_ready_in;

  vrl_fifo #(
    .W     (`VRL_NCH*`VRL_OUT_W),
    .DEPTH (`VRL_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .push_s     (push_s),
    .pop_s      (pop_s)
  );

  // ----------------------------------------------------------------------
  // Per channel registers, meter and output shaping
  // ----------------------------------------------------------------------
  logic [7:0]                    mode_q [`VRL_NCH];
  logic [7:0]                    tune_q [`VRL_NCH];
  logic [7:0]                    cba_q  [`VRL_NCH];
  logic [7:0]                    cbb_q  [`VRL_NCH];
  logic [7:0]                    stat   [`VRL_NCH];
  logic [`VRL_SMP_W-1:0]         smp    [`VRL_NCH];
  logic [`VRL_OUT_W-1:0]         word   [`VRL_NCH];

  genvar ch;
  generate
    for (ch = 0; ch < `VRL_NCH; ch++) begin : g_ch
      logic                          wr_sel;
      logic                          en;
      logic                          cplx;
      logic                          bw43;
      logic [`VRL_TUNE_MSB:0]        tune_eff;
      logic [`VRL_LVL_W-1:0]         peak;
      vrl_pkg::vrl_drop_t            drop_d;
      vrl_pkg::vrl_drop_t            drop_q;
      logic [1:0]                    pen;
      logic                          flag;
      logic [`VRL_SMP_W-1:0]         keep_mask;
      logic [`VRL_SMP_W-1:0]         masked;
      logic                          cb0;
      logic                          cb1;
      logic                          cb2;
      logic                          cb2_on;

      assign wr_sel = reg_wr_in && reg_chan_in[ch];

      // Each channel latches only writes addressed to it.
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          mode_q[ch] <= `VRL_REG_RST;
          tune_q[ch] <= `VRL_REG_RST;
          cba_q[ch]  <= `VRL_REG_RST;
          cbb_q[ch]  <= `VRL_REG_RST;
        end else if (wr_sel) begin
          case (reg_addr_in)
            `VRL_ADDR_MODE: mode_q[ch] <= reg_wdata_in;
            `VRL_ADDR_TUNE: tune_q[ch] <= reg_wdata_in;
            `VRL_ADDR_CBA:  cba_q[ch]  <= reg_wdata_in;
            `VRL_ADDR_CBB:  cbb_q[ch]  <= reg_wdata_in;
            default: begin
            end
          endcase
        end
      end

      assign en   = mode_q[ch][`VRL_MODE_EN];
      assign cplx = mode_q[ch][`VRL_MODE_CPLX];
      // Real mode has only the quarter-rate band.
      assign bw43 = cplx && mode_q[ch][`VRL_MODE_BW43];

      // Out-of-range real codes are clamped rather than trusted.
      always_comb begin
        tune_eff = tune_q[ch][`VRL_TUNE_MSB:0];
        if (!cplx) begin
          if (tune_eff < `VRL_TUNE_RL_MIN) begin
            tune_eff = `VRL_TUNE_RL_MIN;
          end else if (tune_eff > `VRL_TUNE_RL_MAX) begin
            tune_eff = `VRL_TUNE_RL_MAX;
          end
        end
      end

      assign smp[ch] = smp_data_in[ch*`VRL_SMP_W +: `VRL_SMP_W];

      // Channel 0 is taken as I and channel 1 as Q in complex mode.
      vrl_zone_meter u_meter (
        .sys_clk_in   (sys_clk_in),
        .rstn_in      (rstn_in),
        .sample_en_in (sample_en),
        .enable_in    (en),
        .complex_in   (cplx),
        .bw43_in      (bw43),
        .tune_in      (tune_eff),
        .i_in         (smp[ch == 0 ? 0 : (cplx ? 0 : ch)]),
        .q_in         (smp[ch == 0 ? (`VRL_NCH-1) : ch]),
        .peak_out     (peak)
      );

      // Count the thresholds the mask peak exceeds.
      always_comb begin
        drop_d = 3'h0;
        if (peak > `VRL_THR_M30) begin
          drop_d = 3'h1;
        end
        if (peak > `VRL_THR_M24) begin
          drop_d = 3'h2;
        end
        if (peak > `VRL_THR_M18) begin
          drop_d = 3'h3;
        end
        if (peak > `VRL_THR_M12) begin
          drop_d = 3'h4;
        end
        if (peak > `VRL_THR_M06) begin
          drop_d = `VRL_DROP_MAX;
        end
        if (!en) begin
          drop_d = 3'h0;
        end
      end

      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          drop_q <= 3'h0;
        end else begin
          drop_q <= drop_d;
        end
      end

      always_comb begin
        case (drop_q)
          3'h0:    pen = 2'h0;
          3'h1:    pen = 2'h1;
          3'h2:    pen = 2'h2;
          3'h3:    pen = 2'h2;
          default: pen = 2'h3;
        endcase
      end

      assign flag      = (drop_q != 3'h0);
      assign keep_mask = {`VRL_SMP_W{1'b1}} << drop_q;
      // The sample keeps its scale; only low bits are cleared.
      assign masked    = smp[ch] & keep_mask;

      assign cb0    = en && cb_pick(cba_q[ch][`VRL_CB0_LSB +: 2], flag, pen);
      assign cb1    = en && cb_pick(cba_q[ch][`VRL_CB1_LSB +: 2], flag, pen);
      assign cb2    = cb_pick(cbb_q[ch][`VRL_CB2_LSB +: 2], flag, pen);
      // A third control bit takes the sample LSB, hence resolution 13.
      assign cb2_on = en && (cbb_q[ch][`VRL_CB2_LSB +: 2] != 2'h0);

      assign word[ch] = {masked[`VRL_SMP_W-1:1], cb2_on ? cb2 : masked[0], cb1, cb0};
      assign push_s.data[ch*`VRL_OUT_W +: `VRL_OUT_W] = word[ch];

      assign stat[ch]    = {3'h0, flag, 1'b0, drop_q};
      assign reduced_out[ch] = flag;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  logic       rd_ch;
  logic [7:0] rdata_d;

  // Reads come from channel 0 if it is selected, else channel 1; unmapped offsets read 0.
  assign rd_ch = reg_chan_in[0] ? 1'b0 : 1'b1;

  always_comb begin
    case (reg_addr_in)
      `VRL_ADDR_MODE: rdata_d = mode_q[rd_ch];
      `VRL_ADDR_TUNE: rdata_d = tune_q[rd_ch];
      `VRL_ADDR_STAT: rdata_d = stat[rd_ch];
      `VRL_ADDR_CBA:  rdata_d = cba_q[rd_ch];
      `VRL_ADDR_CBB:  rdata_d = cbb_q[rd_ch];
      default:        rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end
  end

endmodule

`default_nettype wire

/* File: vrl_limiter_checker.sv */
`include "vrl_consts.svh"
`default_nettype none

module vrl_limiter_checker (
  input wire logic                             sys_clk_in,
  input wire logic                             rstn_in,
  input wire logic [11:0]                      reg_addr_in,
  input wire logic [`VRL_NCH-1:0]              reg_chan_in,
  input wire logic                             reg_wr_in,
  input wire logic                             reg_rd_in,
  input wire logic [7:0]                       reg_wdata_in,
  input wire logic [7:0]                       reg_rdata_out,
  input wire logic                             smp_valid_in,
  input wire logic                             smp_ready_out,
  input wire logic [`VRL_NCH*`VRL_SMP_W-1:0]   smp_data_in,
  input wire logic                             out_valid_out,
  input wire logic                             out_ready_in,
  input wire logic [`VRL_NCH*`VRL_OUT_W-1:0]   out_data_out,
  input wire logic [`VRL_NCH-1:0]              reduced_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] en_q;
  logic       map_hit;

  // ----------------------------------------------------------------------
  // Enable tracking
  // ----------------------------------------------------------------------
  // Mirrors the per-channel enable so that disabled channels can be watched.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_q <= 2'h0;
    end else if (reg_wr_in && reg_addr_in == `VRL_ADDR_MODE) begin
      en_q <= (en_q & ~reg_chan_in) | (reg_chan_in & {2{reg_wdata_in[`VRL_MODE_EN]}});
    end
  end

  assign map_hit = reg_addr_in inside {`VRL_ADDR_MODE, `VRL_ADDR_TUNE, `VRL_ADDR_STAT, `VRL_ADDR_CBA, `VRL_ADDR_CBB};

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_full_word;
    !smp_ready_out |-> out_valid_out;
  endproperty
  a_full_word: assert property (p_full_word) else $error("full buffer shows no word");
  property p_push_seen;
    smp_valid_in && smp_ready_out |=> out_valid_out;
  endproperty
  a_push_seen: assert property (p_push_seen) else $error("accepted sample lost");
  property p_out_hold;
    out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled word changed");
  property p_rd_hold;
    !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_unmapped;
    reg_rd_in && !map_hit |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mode_back;
    reg_wr_in && reg_addr_in == `VRL_ADDR_MODE && reg_chan_in[0] ##1
    reg_rd_in && !reg_wr_in && reg_addr_in == `VRL_ADDR_MODE && reg_chan_in[0]
    |=> reg_rdata_out[2:0] == $past(reg_wdata_in[2:0], 2);
  endproperty
  a_mode_back: assert property (p_mode_back) else $error("mode read back wrong");
  property p_off_clean;
    (!en_q[1]) [*3] |-> !reduced_out[1];
  endproperty
  a_off_clean: assert property (p_off_clean) else $error("disabled channel reduced");
  property p_stat_range;
    reg_rd_in && reg_addr_in == `VRL_ADDR_STAT |=> reg_rdata_out[2:0] <= 3'h5;
  endproperty
  a_stat_range: assert property (p_stat_range) else $error("more than five bits dropped");
  property p_stat_flag;
    reg_rd_in && reg_addr_in == `VRL_ADDR_STAT |=> reg_rdata_out[4] == (reg_rdata_out[2:0] != 3'h0);
  endproperty
  a_stat_flag: assert property (p_stat_flag) else $error("flag disagrees with drop");

  c_full: cover property (!smp_ready_out);
  c_reduced: cover property (reduced_out[0]);
  c_stall: cover property (out_valid_out && !out_ready_in);
endmodule

bind vrl_limiter vrl_limiter_checker CHK (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_chan_in(reg_chan_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .smp_valid_in(smp_valid_in), .smp_ready_out(smp_ready_out), .smp_data_in(smp_data_in),
  .out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_data_out(out_data_out),
  .reduced_out(reduced_out)
);

`default_nettype wire

/* File: vrl_framer_model.sv */
`include "vrl_consts.svh"
`default_nettype none

module vrl_framer_model (
  input  wire logic                             sys_clk_in,
  input  wire logic                             rstn_in,
  input  wire logic                             valid_in,
  input  wire logic [`VRL_NCH*`VRL_OUT_W-1:0]   data_in,
  input  wire logic                             stall_in,
  input  wire logic                             slow_in,
  input  wire logic [1:0]                       ctrl_bits_in,
  input  wire logic [3:0]                       conv_res_in,
  output logic                                  ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`VRL_NCH*`VRL_OUT_W-1:0] got[$];
  int                             bad_cfg = 0;

  // ----------------------------------------------------------------------
  // Link sink
  // ----------------------------------------------------------------------
  // Word pairs are framed with channel 0 as I and channel 1 as Q.
  // Slow mode accepts every other cycle, so the source must hold its word.
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ready_out <= 1'b0;
    end else begin
      if (valid_in && ready_out) got.push_back(data_in);
      if (ctrl_bits_in == 2'h3 && conv_res_in != 4'hd) bad_cfg++;
      ready_out <= !stall_in && !(slow_in && ready_out);
    end
  end
endmodule

`default_nettype wire

/* File: tb.sv */
`include "vrl_consts.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] MD = `VRL_ADDR_MODE;
  localparam logic [11:0] TN = `VRL_ADDR_TUNE;
  logic                            sys_clk_in = 1'b0;
  logic                            rstn_in = 1'b0;
  logic [11:0]                     addr = 12'h000;
  logic [1:0]                      chan = 2'h0;
  logic                            wr_en = 1'b0;
  logic                            rd_en = 1'b0;
  logic [7:0]                      wdata = 8'h00;
  logic [7:0]                      rdata;
  logic [7:0]                      q;
  logic                            sv = 1'b0;
  logic                            srdy;
  logic [`VRL_NCH*`VRL_SMP_W-1:0]  sdata = '0;
  logic                            ov;
  logic                            ordy;
  logic [`VRL_NCH*`VRL_OUT_W-1:0]  od;
  logic [`VRL_NCH*`VRL_OUT_W-1:0]  w;
  logic [1:0]                      red;
  logic                            stall = 1'b0;
  logic                            slow = 1'b0;
  logic [11:0]                     regs[5] = '{MD, TN, `VRL_ADDR_STAT, `VRL_ADDR_CBA, `VRL_ADDR_CBB};
  int                              fails = 0;
  int                              comparisons = 0;
  int                              cycles = 0;
  int                              n;

  always #10 sys_clk_in = ~sys_clk_in;

  vrl_limiter DUT (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_chan_in(chan), .reg_wr_in(wr_en),
    .reg_rd_in(rd_en), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .smp_valid_in(sv), .smp_ready_out(srdy),
    .smp_data_in(sdata), .out_valid_out(ov), .out_ready_in(ordy), .out_data_out(od), .reduced_out(red)
  );
  vrl_framer_model FRM (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .valid_in(ov), .data_in(od), .stall_in(stall),
    .slow_in(slow), .ctrl_bits_in(2'h3), .conv_res_in(4'hd), .ready_out(ordy)
  );

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Strobes stay up between calls; repeating an access is harmless.
  task automatic wr(input logic [11:0] a, input logic [1:0] c, input logic [7:0] d);
    addr = a;
    chan = c;
    wdata = d;
    wr_en = 1'b1;
    rd_en = 1'b0;
    @(posedge sys_clk_in);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] c);
    addr = a;
    chan = c;
    rd_en = 1'b1;
    wr_en = 1'b0;
    @(posedge sys_clk_in);
    #1 q = rdata;
  endtask

  // Kind 0: alternating tone at half rate; 1 and 2: complex tone at plus or minus a quarter rate.
  function automatic logic [27:0] smp(input int k, input int a, input int i);
    int di;
    int dq;
    di = (k == 0) ? ((i % 2) ? -a : a) : ((i % 4) == 0 ? a : (i % 4) == 2 ? -a : 0);
    dq = (k == 0) ? 'h1555 : ((i % 4) == 1 ? a : (i % 4) == 3 ? -a : 0) * (k == 1 ? 1 : -1);
    return {dq[13:0], di[13:0]};
  endfunction

  task automatic run(input int k, input int a, input int len);
    for (int i = 0; i < len; i++) begin
      sdata = smp(k, a, i);
      sv = 1'b1;
      while (!srdy) begin
        @(posedge sys_clk_in);
        #1;
      end
      @(posedge sys_clk_in);
      #1;
    end
    sv = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1 w = FRM.got[$];
  endtask

  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk_in);
    #1 rstn_in = 1'b1;
    for (int c = 1; c < 3; c++) foreach (regs[j]) begin
      rd(regs[j], c[1:0]);
      chk("reset value", 0, q);
    end
    wr(MD, 2'h0, 8'h07);
    rd(MD, 2'h1);
    chk("mode without channel", 0, q[2:0]);
    wr(`VRL_ADDR_STAT, 2'h3, 8'hff);
    rd(`VRL_ADDR_STAT, 2'h1);
    chk("status write", 0, q);
    wr(12'h431, 2'h3, 8'h5a);
    rd(12'h431, 2'h1);
    chk("unmapped", 0, q);
    for (int t = 0; t < 16; t++) begin
      wr(TN, 2'h1, 8'(t));
      rd(TN, 2'h1);
      chk("tuning code", t, q[3:0]);
    end
    foreach (regs[j]) if (j < 3) begin
      wr(MD, 2'h1, 8'h01 | 8'(j * 2) | 8'(j / 2 * 4));
      rd(MD, 2'h1);
      chk("mode", 1 | (j * 2) | (j / 2 * 4), q[2:0]);
    end
    rd(MD, 2'h2);
    chk("other channel mode", 0, q[2:0]);
    wr(MD, 2'h3, 8'h00);
    $display("test registers done");
    stall = 1'b1;
    @(posedge sys_clk_in);
    #1 n = 0;
    sv = 1'b1;
    while (srdy && n < 20) begin
      sdata = {14'(n), 14'(n + 7)};
      @(posedge sys_clk_in);
      #1 n++;
    end
    sv = 1'b0;
    chk("buffer depth", `VRL_FIFO_DEPTH, n);
    chk("full ready", 0, srdy);
    stall = 1'b0;
    slow = 1'b1;
    for (int k = 0; k < 100 && FRM.got.size() < 16; k++) @(posedge sys_clk_in);
    #1 slow = 1'b0;
    for (int k = 0; k < 16; k++) chk("drained word", {14'(k), 2'h0, 14'(k + 7), 2'h0}, FRM.got[k]);
    $display("test buffer done");
    wr(MD, 2'h1, 8'h01);
    wr(TN, 2'h1, 8'h04);
    wr(`VRL_ADDR_CBA, 2'h1, 8'h21);
    wr(`VRL_ADDR_CBB, 2'h1, 8'h03);
    run(0, 60, 301);
    chk("quiet word", 32'h555400f0, w);
    chk("quiet reduced", 0, red);
    run(0, 8191, 301);
    chk("loud word", 16'h7f87, w[15:0] & 16'hffbf);
    chk("other channel word", 16'h5554, w[31:16]);
    chk("loud reduced", 1, red);
    rd(`VRL_ADDR_STAT, 2'h1);
    chk("dropped bits", 1, q[4] && q[2:0] >= 3'h4 && q[2:0] <= 3'h5);
    run(0, 0, 3001);
    chk("recovered word", 0, w[15:0]);
    chk("recovered reduced", 0, red);
    $display("test real mode done");
    wr(MD, 2'h1, 8'h03);
    run(1, 8191, 2001);
    chk("passband word", 16'h7ff8, w[15:0]);
    chk("passband reduced", 0, red);
    wr(MD, 2'h1, 8'h07);
    run(2, 8191, 401);
    chk("image reduced", 1, red);
    chk("framer setup", 0, FRM.bad_cfg);
    $display("test complex mode done");
    final_report();
  end
endmodule

`default_nettype wire
